// >>> hdl/rom_patch_fetch_redirect.sv
// Fetch-path patch unit that swaps patched ROM words for a jump to zero.
`timescale 1ns/1ps
module rom_patch_fetch_redirect
    import patch_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    input  wire logic                      fetch_valid,
    input  wire logic [ADDR_WIDTH-1:0]     fetch_address,
    input  wire logic [INSN_WIDTH-1:0]     rom_instruction,
    input  wire logic                      interrupt_taken,
    input  wire logic                      control_byte_write,
    input  wire logic [CTRL_WIDTH-1:0]     control_byte_data,
    input  wire logic                      control_bit_write,
    input  wire logic [ADDR_BIT_SEL_W-1:0] control_bit_select,
    input  wire logic                      control_bit_value,
    input  wire logic                      address_write,
    input  wire logic [1:0]                address_select,
    input  wire logic [ADDR_WIDTH-1:0]     address_data,
    input  wire logic                      flags_write,
    input  wire logic [CHANNELS-1:0]       flags_data,
    output logic      [INSN_WIDTH-1:0]     fetch_instruction,
    output logic                           fetch_substituted,
    output logic      [CTRL_WIDTH-1:0]     patch_enable_control,
    output logic      [CHANNELS-1:0]       patch_request_flags,
    output logic      [ADDR_WIDTH-1:0]     patch_address_0,
    output logic      [ADDR_WIDTH-1:0]     patch_address_1,
    output logic      [ADDR_WIDTH-1:0]     patch_address_2,
    output logic      [ADDR_WIDTH-1:0]     patch_address_3
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_WIDTH-1:0]              control;
        logic [CHANNELS-1:0]                flags;
        logic [CHANNELS-1:0][ADDR_WIDTH-1:0] addresses;
    } state_type;

    state_type            state_q;
    state_type            state_d;
    logic [CHANNELS-1:0]  hit;
    logic                 substitute;

    // ----------------------------------------------------------------
    // Comparators
    // ----------------------------------------------------------------
    // four channels
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
        patch_compare u_compare (
            .fetch_address (fetch_address),
            .patch_address (state_q.addresses[ch]),
            .enable        (state_q.control[ch]),
            .hit           (hit[ch])
        );
    end

    assign substitute = fetch_valid && (|hit) && !interrupt_taken;

    // ----------------------------------------------------------------
    // Fetch path
    // ----------------------------------------------------------------
    // The swap is combinational so the fetch sees no added latency.
    // jump to zero
    assign fetch_instruction = substitute ? JUMP_ZERO_INSN : rom_instruction;
    assign fetch_substituted = substitute;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // A flag clear from software loses to a set in the same cycle.
    always_comb begin
        state_d = state_q;
        if (control_byte_write) begin
            state_d.control = control_byte_data;
        end else if (control_bit_write) begin
            state_d.control[control_bit_select] = control_bit_value;
        end
        if (address_write) begin
            state_d.addresses[address_select] = address_data;
        end
        if (flags_write) begin
            state_d.flags = state_q.flags & flags_data;
        end
        if (substitute) begin
            state_d.flags = state_d.flags | hit;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q.control   <= CTRL_RESET;
            state_q.flags     <= FLAGS_RESET;
            state_q.addresses <= {CHANNELS{ADDR_RESET}};
        end else begin
            state_q <= state_d;
        end
    end

    assign patch_enable_control = state_q.control;
    assign patch_request_flags  = state_q.flags;
    assign patch_address_0      = state_q.addresses[0];
    assign patch_address_1      = state_q.addresses[1];
    assign patch_address_2      = state_q.addresses[2];
    assign patch_address_3      = state_q.addresses[3];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // A substitution is an enabled hit in a slot that no interrupt holds.
    sequence enabled_hit_s;
        fetch_valid && (|hit) && !interrupt_taken;
    endsequence

    // A software clear of the flags with no substitution in the same slot.
    sequence plain_clear_s;
        flags_write && !substitute;
    endsequence

    // A slot in which software leaves the flags alone.
    sequence flags_idle_s;
        !flags_write;
    endsequence

    // The jump must be on the bus in the very slot of the hit, or the CPU
    // would execute the faulty ROM word first.
    jump_on_hit_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        enabled_hit_s |-> fetch_instruction == JUMP_ZERO_INSN &&
            fetch_substituted)
        else $error("Enabled hit did not deliver the jump.");

    // Without a fetch the ROM word passes untouched and nothing is marked.
    idle_passes_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        !fetch_valid |-> fetch_instruction == rom_instruction &&
            !fetch_substituted)
        else $error("ROM word altered outside a fetch.");

    // The flag of every channel that hit must read one in the next cycle.
    flag_set_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        enabled_hit_s |=> (patch_request_flags & $past(hit)) == $past(hit))
        else $error("Substitution did not set its flag.");

    // Channels stay apart: only the channels that hit gain a flag.
    channel_isolate_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        flags_idle_s |=> patch_request_flags ==
            ($past(patch_request_flags) |
            ($past(hit) & {CHANNELS{$past(substitute)}})))
        else $error("A flag changed on a channel that did not hit.");

    // Each address write lands in the register that it selects.
    address_load_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        address_write |=> state_q.addresses[$past(address_select)] ==
            $past(address_data))
        else $error("Patch address write lost.");

    // With every enable clear no match may reach the fetch path.
    disabled_none_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        (patch_enable_control[3:0] == 4'h0) |->
            !fetch_substituted)
        else $error("Substitution with all channels disabled.");

    // A whole-byte write replaces all eight control bits.
    byte_write_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        control_byte_write |=> patch_enable_control ==
            $past(control_byte_data))
        else $error("Whole-byte control write lost.");

    // A single-bit write lands in the selected bit when no byte write wins.
    bit_write_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        (control_bit_write && !control_byte_write) |=>
        patch_enable_control[$past(control_bit_select)] ==
        $past(control_bit_value))
        else $error("Single-bit control write lost.");

    // An interrupt in the same slot keeps the ROM word and marks nothing.
    irq_wins_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        interrupt_taken |-> fetch_instruction == rom_instruction &&
            !fetch_substituted)
        else $error("Substitution during interrupt.");

    // A set flag survives every slot in which software does not write.
    flags_keep_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        !flags_write |=> (patch_request_flags & $past(patch_request_flags))
        == $past(patch_request_flags))
        else $error("A set flag was lost.");

    // A software write keeps only the flags whose mask bit is one.
    flag_clear_a: assert property (@(posedge clock)
        disable iff (!reset_n)
        plain_clear_s |=> patch_request_flags ==
            ($past(patch_request_flags) & $past(flags_data)))
        else $error("Flag clear did not follow the mask.");

    // Reset must leave every channel disabled with no request pending.
    // This one runs through reset on purpose, so it has no disable.
    reset_zero_a: assert property (@(posedge clock)
        !reset_n |=> patch_request_flags == FLAGS_RESET &&
            patch_enable_control == CTRL_RESET)
        else $error("Flags or enables not zero after reset.");

endmodule

// >>> hdl/patch_pkg.sv
// Package of constants for the fetch-path patch unit.
package patch_pkg;
    localparam int          CHANNELS       = 4;
    localparam int          ADDR_WIDTH     = 32;
    localparam int          INSN_WIDTH     = 32;
    localparam int          CTRL_WIDTH     = 8;
    localparam logic [31:0] JUMP_TARGET    = 32'h0000_0000;
    // Register-indirect jump through the zero register, halfword in low bits.
    localparam logic [31:0] JUMP_ZERO_INSN = 32'h0000_0060;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [3:0]  FLAGS_RESET    = 4'h0;
    localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
    localparam int          ADDR_BIT_SEL_W = 3;
endpackage

// >>> hdl/patch_compare.sv
// One patch comparison channel: address match gated by its enable.
`timescale 1ns/1ps
module patch_compare
    import patch_pkg::*;
(
    input  wire logic [ADDR_WIDTH-1:0] fetch_address,
    input  wire logic [ADDR_WIDTH-1:0] patch_address,
    input  wire logic                  enable,
    output logic                       hit
);
    // A disabled channel never hits even when the addresses agree.
    assign hit = enable && (fetch_address == patch_address);
endmodule

// >>> verification/rom_model.sv
// Behavioural ROM that answers each fetch with a word of its own.
`timescale 1ns/1ps
module rom_model
    import patch_pkg::*;
(
    input  wire logic [ADDR_WIDTH-1:0] fetch_address,
    output logic      [INSN_WIDTH-1:0] rom_instruction
);
    // code words only
    // Inverted address keeps each word clear of the jump encoding, except at address FFFFFF9F.
    assign rom_instruction = ~fetch_address;
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the fetch-path patch unit.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
    import patch_pkg::*;
;
    typedef struct packed {
        logic [31:0] a; logic intr; logic sub; logic [3:0] flg;
    } row_type;
    logic clock = 0, reset_n = 0, fetch_valid = 0, interrupt_taken = 0;
    logic control_byte_write = 0, control_bit_write = 0;
    logic control_bit_value = 0, address_write = 0, flags_write = 0;
    logic [7:0]  control_byte_data = 0, patch_enable_control;
    logic [2:0]  control_bit_select = 0;
    logic [1:0]  address_select = 0;
    logic [3:0]  flags_data = 0, patch_request_flags;
    logic [31:0] fetch_address = 0, address_data = 0, rom_instruction;
    logic [31:0] fetch_instruction, pa0, pa1, pa2, pa3;
    logic        fetch_substituted;
    int          errors = 0, cmp_count = 0;
    // Fetches walk the channels one by one, so flags build up.
    // interrupt slot row
    // The interrupt row sets no flag, so a handler must go by its level.
    row_type rows [6] = '{
        '{32'h0000_0104, 1'b0, 1'b1, 4'h2}, '{32'h0000_0100, 1'b1, 1'b0, 4'h2},
        '{32'h0000_0102, 1'b0, 1'b0, 4'h2}, '{32'h0000_0100, 1'b0, 1'b1, 4'h3},
        '{32'h0000_010C, 1'b0, 1'b1, 4'hB}, '{32'h0000_0108, 1'b0, 1'b1, 4'hF}};

    always #50 clock = ~clock;

    rom_model u_rom_model (.fetch_address(fetch_address),
        .rom_instruction(rom_instruction));
    rom_patch_fetch_redirect u_rom_patch_fetch_redirect (
        .clock(clock), .reset_n(reset_n), .fetch_valid(fetch_valid),
        .fetch_address(fetch_address), .rom_instruction(rom_instruction),
        .interrupt_taken(interrupt_taken),
        .control_byte_write(control_byte_write),
        .control_byte_data(control_byte_data),
        .control_bit_write(control_bit_write),
        .control_bit_select(control_bit_select),
        .control_bit_value(control_bit_value),
        .address_write(address_write), .address_select(address_select),
        .address_data(address_data), .flags_write(flags_write),
        .flags_data(flags_data), .fetch_instruction(fetch_instruction),
        .fetch_substituted(fetch_substituted),
        .patch_enable_control(patch_enable_control),
        .patch_request_flags(patch_request_flags),
        .patch_address_0(pa0), .patch_address_1(pa1),
        .patch_address_2(pa2), .patch_address_3(pa3));

    // One fetch slot then one idle slot; outputs are combinational, so
    // they are checked mid-cycle while the request still stands. The idle
    // slot keeps two fetches from lowering and raising valid at one time.
    task automatic fetch(input logic [31:0] a, input logic i, input logic s);
        fetch_valid = 1;
        fetch_address = a;
        interrupt_taken = i;
        #10;
        `CHK(fetch_substituted, s)
        `CHK(fetch_instruction, s ? JUMP_ZERO_INSN : ~a)
        @(negedge clock);
        fetch_valid = 0;
        interrupt_taken = 0;
        @(negedge clock);
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clock);
        reset_n = 1;
        `CHK(patch_enable_control, CTRL_RESET)
        `CHK(patch_request_flags, FLAGS_RESET)
        fetch(32'h0000_0000, 1'b0, 1'b0);
        // patches on code only
        // Patched addresses never hold an access to the patch registers.
        for (int i = 0; i < 4; i++) begin
            address_write = 1;
            address_select = i[1:0];
            address_data = 32'h0000_0100 + 32'(i * 4);
            control_bit_write = 1;
            control_bit_select = i[2:0];
            control_bit_value = 1;
            @(negedge clock);
        end
        address_write = 0;
        control_bit_write = 0;
        `CHK(patch_enable_control, 8'h0F)
        `CHK(pa0, 32'h0000_0100)
        `CHK(pa1, 32'h0000_0104)
        `CHK(pa2, 32'h0000_0108)
        `CHK(pa3, 32'h0000_010C)
        $display("reset and setup done");
        foreach (rows[k]) begin
            fetch(rows[k].a, rows[k].intr, rows[k].sub);
            `CHK(patch_request_flags, rows[k].flg)
        end
        $display("table done");
        // A zero in the mask clears only channel 0.
        flags_write = 1;
        flags_data = 4'hE;
        control_byte_write = 1;
        control_byte_data = 8'hA5;
        @(negedge clock);
        flags_write = 0;
        control_byte_write = 0;
        `CHK(patch_request_flags, 4'hE)
        `CHK(patch_enable_control, 8'hA5)
        fetch(32'h0000_0104, 1'b0, 1'b0);
        fetch(32'h0000_0100, 1'b0, 1'b1);
        `CHK(patch_request_flags, 4'hF)
        $display("clear and disable done");
        // A clear of every flag in the slot of a hit: the set wins.
        flags_write = 1;
        flags_data = 4'h0;
        fetch_valid = 1;
        fetch_address = 32'h0000_0100;
        #10;
        `CHK(fetch_substituted, 1'b1)
        @(negedge clock);
        flags_write = 0;
        fetch_valid = 0;
        `CHK(patch_request_flags, 4'h1)
        // A byte write beats a bit write in the same cycle.
        control_byte_write = 1;
        control_byte_data = 8'h00;
        control_bit_write = 1;
        control_bit_select = 3'h0;
        control_bit_value = 1;
        @(negedge clock);
        control_byte_write = 0;
        control_bit_write = 0;
        `CHK(patch_enable_control, 8'h00)
        $display("set, clear and write order done");
        // A reset in mid-run brings every register back to zero.
        control_byte_write = 1;
        control_byte_data = 8'h0F;
        @(negedge clock);
        control_byte_write = 0;
        reset_n = 0;
        @(negedge clock);
        reset_n = 1;
        `CHK(patch_enable_control, CTRL_RESET)
        `CHK(patch_request_flags, FLAGS_RESET)
        `CHK(pa0, ADDR_RESET)
        `CHK(pa1, ADDR_RESET)
        `CHK(pa2, ADDR_RESET)
        `CHK(pa3, ADDR_RESET)
        fetch(32'h0000_0000, 1'b0, 1'b0);
        $display("mid-run reset done");
        end_of_test();
    end
endmodule
